// File: fifo_flag_offset_retransmit.sv
`timescale 1ns/1ns
module fifo_flag_offset_retransmit
  import fifo_flag_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int DEPTH = DEPTH_WORDS
) (
  input wire logic i_clk, // 250 MHz clock
  input wire logic i_arst_n, // Full reset, async
  input wire logic i_partial_reset_n, // Partial reset, sync
  input wire logic i_wclk_en, // Write clock edge
  input wire logic i_rclk_en, // Read clock edge
  input wire logic i_sclk_en, // Serial clock edge
  input wire logic i_write_en_n, // Write enable
  input wire logic i_read_en_n, // Read enable
  input wire logic i_load_select_n, // Offset access select
  input wire logic i_serial_enable_n, // Serial shift enable
  input wire logic i_serial_in, // Serial bit / mode strap
  input wire logic i_default_offset_pick_a, // Default pick a
  input wire logic i_default_offset_pick_b, // Default pick b
  input wire logic i_flag_timing_select, // High: sync flags
  input wire logic i_mark, // Mark for retransmit
  input wire logic i_retransmit_n, // Retransmit request
  input wire logic [DATA_W-1:0] i_write_data_in, // Write data
  output logic [DATA_W-1:0] o_read_data_out, // Read data
  output logic o_empty_flag_n, // Empty / output ready
  output logic o_full_flag_n, // Full / input ready
  output logic o_almost_empty_flag_n, // Almost empty
  output logic o_almost_full_flag_n, // Almost full
  output logic o_fall_through_mode // Timing mode in force
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 2;
  localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // ==========================================================
  // State
  logic cfg_pending, next_cfg_pending;
  strap_s straps, next_straps;
  logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] mark_ptr, next_mark_ptr;
  logic out_valid, next_out_valid;
  rt_state_e rt_state, next_rt_state;
  logic [1:0] par_step, next_par_step, rb_step, next_rb_step;
  logic [5:0] ser_idx, next_ser_idx;
  logic ser_busy, next_ser_busy;
  logic [1:0] af_wait, next_af_wait, ae_wait, next_ae_wait;
  logic [DATA_W-1:0] next_read_data;
  logic next_ef_n, next_ff_n, next_ae_n, next_af_n;
  logic [DATA_W-1:0] mem [DEPTH];

  logic [OFF_W-1:0] off_empty, off_full;
  logic run, fall_through_mode, mode_now;
  logic mem_wr, rd_std, ft_fill, ft_pop, mem_rd, rb, pw, ss;
  logic ser_done, mark_block;
  logic [AW:0] mem_cnt, next_cnt;
  logic [CW-1:0] total, ae_thr, af_thr;
  logic ae_ok, af_hit, af_gate, ae_gate;
  logic [DATA_W-1:0] rb_word;
  logic [OFF_W-1:0] rb_off;

  // ==========================================================
  // Decode
  assign run = !cfg_pending && i_partial_reset_n;
  assign fall_through_mode = straps.fall_through;
  assign mem_cnt = wr_ptr - rd_ptr;
  // Writes may not reach the marked word while a mark is held
  assign mark_block = (rt_state != RT_IDLE) &&
    ((wr_ptr - mark_ptr) == DEPTH_P);
  assign mem_wr = run && i_wclk_en && i_load_select_n && !i_write_en_n &&
    (mem_cnt != DEPTH_P) && !mark_block;
  assign rd_std = run && !fall_through_mode && i_rclk_en && i_load_select_n &&
    !i_read_en_n && (mem_cnt != '0) && (rt_state != RT_SETUP);
  assign ft_pop = run && fall_through_mode && i_rclk_en && i_load_select_n &&
    out_valid && !i_read_en_n;
  assign ft_fill = run && fall_through_mode && i_rclk_en && i_load_select_n &&
    (mem_cnt != '0) && (!out_valid || !i_read_en_n);
  assign mem_rd = rd_std || ft_fill;
  // Offset access is mode independent
  assign rb = run && i_rclk_en && !i_load_select_n && !i_read_en_n &&
    i_write_en_n && i_serial_enable_n;
  assign pw = run && i_wclk_en && !i_load_select_n && !i_write_en_n &&
    !straps.serial_prog;
  assign ss = run && i_sclk_en && !i_load_select_n && !i_serial_enable_n &&
    straps.serial_prog;
  assign ser_done = ss && (ser_idx == SERIAL_LAST);

  offset_store #(.DATA_W(DATA_W)) u_empty_off (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_load_default(cfg_pending),
    .i_default(default_offset({i_load_select_n, i_default_offset_pick_b,
      i_default_offset_pick_a})),
    .i_par_lo(pw && (par_step == 2'h0)),
    .i_par_hi(pw && (par_step == 2'h1)),
    .i_par_data(i_write_data_in),
    .i_ser_en(ss && (ser_idx < 6'(OFF_W))),
    .i_ser_idx(ser_idx[4:0]),
    .i_ser_bit(i_serial_in),
    .o_value(off_empty)
  );

  offset_store #(.DATA_W(DATA_W)) u_full_off (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_load_default(cfg_pending),
    .i_default(default_offset({i_load_select_n, i_default_offset_pick_b,
      i_default_offset_pick_a})),
    .i_par_lo(pw && (par_step == 2'h2)),
    .i_par_hi(pw && (par_step == 2'h3)),
    .i_par_data(i_write_data_in),
    .i_ser_en(ss && (ser_idx >= 6'(OFF_W))),
    .i_ser_idx(5'(ser_idx - 6'(OFF_W))),
    .i_ser_bit(i_serial_in),
    .o_value(off_full)
  );

  always_comb begin
    rb_off = rb_step[1] ? off_full : off_empty;
    rb_word = '0;
    if (rb_step[0]) begin
      rb_word[OFF_W-PART_LO_W-1:0] = rb_off[OFF_W-1:PART_LO_W];
    end else begin
      rb_word[PART_LO_W-1:0] = rb_off[PART_LO_W-1:0];
    end
  end

  // ==========================================================
  // Pointers, data path and retransmit
  always_comb begin
    next_cfg_pending = 1'b0;
    next_straps = straps;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_mark_ptr = mark_ptr;
    next_out_valid = out_valid;
    next_rt_state = rt_state;
    next_read_data = o_read_data_out;
    next_par_step = pw ? par_step + 2'h1 : par_step;
    next_rb_step = rb ? rb_step + 2'h1 : rb_step;
    next_ser_idx = ser_idx;
    next_ser_busy = ser_busy;
    if (cfg_pending) begin
      next_straps = '{fall_through: i_serial_in,
        serial_prog: i_load_select_n,
        flag_sync: i_flag_timing_select};
    end
    if (ss) begin
      // Position survives pauses in shifting
      next_ser_idx = ser_done ? 6'h00 : ser_idx + 6'h01;
      next_ser_busy = !ser_done;
    end
    if (mem_wr) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (mem_rd) begin
      next_rd_ptr = rd_ptr + 1'b1;
      next_read_data = mem[rd_ptr[AW-1:0]];
      next_out_valid = 1'b1;
    end else if (ft_pop) begin
      next_out_valid = 1'b0;
    end
    if (rb) begin
      next_read_data = rb_word;
    end
    if (run && !fall_through_mode && i_rclk_en) begin
      case (rt_state)
        RT_IDLE: begin
          if (i_mark && o_empty_flag_n) begin
            // Word now in the output register is the first one
            next_rt_state = RT_MARKED;
            next_mark_ptr = rd_ptr - 1'b1;
          end
        end
        RT_MARKED: begin
          if (!i_mark) begin
            next_rt_state = RT_IDLE;
          end else if (!i_retransmit_n) begin
            next_rt_state = RT_SETUP;
            next_rd_ptr = mark_ptr;
          end
        end
        RT_SETUP: begin
          next_rd_ptr = mark_ptr;
          if (!i_mark) begin
            next_rt_state = RT_IDLE;
          end else if (i_retransmit_n) begin
            next_rt_state = RT_MARKED;
          end
        end
        default: next_rt_state = RT_IDLE;
      endcase
    end
    if (!i_partial_reset_n && !cfg_pending) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_out_valid = 1'b0;
      next_rt_state = RT_IDLE;
      next_read_data = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_pending <= 1'b1;
      straps <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      mark_ptr <= '0;
      out_valid <= 1'b0;
      rt_state <= RT_IDLE;
      o_read_data_out <= '0;
      par_step <= 2'h0;
      rb_step <= 2'h0;
      ser_idx <= 6'h00;
      ser_busy <= 1'b0;
    end else begin
      cfg_pending <= next_cfg_pending;
      straps <= next_straps;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      mark_ptr <= next_mark_ptr;
      out_valid <= next_out_valid;
      rt_state <= next_rt_state;
      o_read_data_out <= next_read_data;
      par_step <= next_par_step;
      rb_step <= next_rb_step;
      ser_idx <= next_ser_idx;
      ser_busy <= next_ser_busy;
    end
  end

  // Storage carries no reset, so it sits in its own process
  always_ff @(posedge i_clk) begin
    if (mem_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_write_data_in;
    end
  end

  // ==========================================================
  // Flags
  assign next_cnt = next_wr_ptr - next_rd_ptr;
  assign total = CW'(next_cnt) + CW'(next_out_valid && fall_through_mode);
  assign ae_thr = CW'(off_empty) + (fall_through_mode ? CW'(2) : CW'(1));
  assign af_thr = DEPTH_C + CW'(fall_through_mode) - CW'(off_full);
  assign ae_ok = total >= ae_thr;
  assign af_hit = total >= af_thr;
  // Hold almost full inactive and almost empty asserted during a serial load and until offsets settle
  assign af_gate = !ser_busy && !ss &&
    ((af_wait == 2'h0) || (af_wait == 2'h1 && i_wclk_en));
  assign ae_gate = !ser_busy && !ss &&
    ((ae_wait == 2'h0) || (ae_wait == 2'h1 && i_rclk_en));
  assign mode_now = cfg_pending ? i_serial_in : fall_through_mode;

  always_comb begin
    next_af_wait = af_wait;
    next_ae_wait = ae_wait;
    if (ser_done) begin
      next_af_wait = SETTLE_EDGES;
      next_ae_wait = SETTLE_EDGES;
    end else begin
      if (i_wclk_en && af_wait != 2'h0) next_af_wait = af_wait - 2'h1;
      if (i_rclk_en && ae_wait != 2'h0) next_ae_wait = ae_wait - 2'h1;
    end
    if (fall_through_mode) begin
      next_ef_n = !next_out_valid;
      next_ff_n = (next_cnt == DEPTH_P);
    end else begin
      next_ef_n = (next_cnt != '0) && (next_rt_state != RT_SETUP);
      next_ff_n = (next_cnt != DEPTH_P);
    end
    next_af_n = o_almost_full_flag_n;
    next_ae_n = o_almost_empty_flag_n;
    if (!af_gate) begin
      next_af_n = 1'b1;
    end else if (straps.flag_sync) begin
      if (i_wclk_en) next_af_n = !af_hit;
    end else if (i_wclk_en && af_hit) begin
      next_af_n = 1'b0;
    end else if (i_rclk_en && !af_hit) begin
      next_af_n = 1'b1;
    end
    if (!ae_gate) begin
      next_ae_n = 1'b0;
    end else if (straps.flag_sync) begin
      if (i_rclk_en) next_ae_n = ae_ok;
    end else if (i_rclk_en && !ae_ok) begin
      next_ae_n = 1'b0;
    end else if (i_wclk_en && ae_ok) begin
      next_ae_n = 1'b1;
    end
    if (cfg_pending || !i_partial_reset_n) begin
      next_ef_n = mode_now;
      next_ff_n = !mode_now;
      next_af_n = 1'b1;
      next_ae_n = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      af_wait <= 2'h0;
      ae_wait <= 2'h0;
      o_empty_flag_n <= 1'b0;
      o_full_flag_n <= 1'b1;
      o_almost_full_flag_n <= 1'b1;
      o_almost_empty_flag_n <= 1'b0;
      o_fall_through_mode <= 1'b0;
    end else begin
      af_wait <= next_af_wait;
      ae_wait <= next_ae_wait;
      o_empty_flag_n <= next_ef_n;
      o_full_flag_n <= next_ff_n;
      o_almost_full_flag_n <= next_af_n;
      o_almost_empty_flag_n <= next_ae_n;
      o_fall_through_mode <= next_straps.fall_through;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_default_load: assert property ((cfg_pending && i_arst_n) |=>
    off_empty == default_offset({$past(i_load_select_n),
      $past(i_default_offset_pick_b), $past(i_default_offset_pick_a)}))
    else $error("default offset not loaded");
  chk_mode_strap: assert property ((cfg_pending && i_arst_n) |=>
    straps.fall_through == $past(i_serial_in)
      && straps.serial_prog == $past(i_load_select_n))
    else $error("mode strap not captured");
  chk_serial_ignore: assert property (
    (i_sclk_en && !i_load_select_n && i_serial_enable_n) |=>
      $stable(ser_idx) && $stable(off_full))
    else $error("serial edge taken while disabled");
  chk_serial_settle: assert property (ser_done |=>
    af_wait == 2'h3 && ae_wait == 2'h3 && ser_idx == 6'h00)
    else $error("settle count wrong after serial load");
  chk_af_sync: assert property ((straps.flag_sync && !i_wclk_en &&
    !cfg_pending && i_partial_reset_n) |=> $stable(o_almost_full_flag_n))
    else $error("almost full moved without write edge");
  chk_ae_async: assert property ((!straps.flag_sync &&
    !cfg_pending && i_partial_reset_n && !$past(cfg_pending) &&
    $past(i_partial_reset_n) && $fell(o_almost_empty_flag_n) && ae_gate)
    |-> $past(i_rclk_en))
    else $error("almost empty fell without read edge");
  chk_full_std: assert property ((!fall_through_mode && run) |=>
    o_full_flag_n == (mem_cnt != DEPTH_P))
    else $error("full flag disagrees with count");
  chk_rt_setup: assert property ((rt_state == RT_SETUP) |->
    !o_empty_flag_n ##0 !rd_std)
    else $error("reads allowed during retransmit setup");
  chk_mark_write: assert property (mark_block && i_partial_reset_n
    |=> $stable(wr_ptr))
    else $error("write overran marked data");
  chk_partial_keep: assert property (!i_partial_reset_n &&
    !cfg_pending |=> $stable(off_empty) && $stable(off_full)
      && $stable(straps) && wr_ptr == '0 && rd_ptr == '0)
    else $error("partial reset disturbed offsets");

  cov_serial_done: cover property (ser_done);
  cov_retransmit: cover property (rt_state == RT_MARKED ##1
    rt_state == RT_SETUP);
  cov_full: cover property (!o_full_flag_n && !fall_through_mode);
  cov_readback: cover property (rb ##2 rb);

endmodule // fifo_flag_offset_retransmit

// File: fifo_flag_pkg.sv
package fifo_flag_pkg;

  // ==========================================================
  // Sizes
  localparam int DATA_W_DEF = 36;
  localparam int DEPTH_WORDS = 524288;
  localparam int OFF_W = 19;
  localparam int PART_LO_W = 10;
  localparam int SERIAL_BITS = 2 * OFF_W;
  localparam logic [5:0] SERIAL_LAST = 6'h25;
  localparam logic [1:0] SETTLE_EDGES = 2'h3;

  // ==========================================================
  // Default offsets, indexed by {load select, pick b, pick a}
  localparam logic [OFF_W-1:0] DEF_OFF_HLL = 19'h003ff;
  localparam logic [OFF_W-1:0] DEF_OFF_LHL = 19'h001ff;
  localparam logic [OFF_W-1:0] DEF_OFF_LLH = 19'h000ff;
  localparam logic [OFF_W-1:0] DEF_OFF_LLL = 19'h0007f;
  localparam logic [OFF_W-1:0] DEF_OFF_LHH = 19'h0003f;
  localparam logic [OFF_W-1:0] DEF_OFF_HHL = 19'h0001f;
  localparam logic [OFF_W-1:0] DEF_OFF_HLH = 19'h0000f;
  localparam logic [OFF_W-1:0] DEF_OFF_HHH = 19'h00007;

  // ==========================================================
  // Types
  typedef struct packed {
    logic fall_through;
    logic serial_prog;
    logic flag_sync;
  } strap_s;

  typedef enum logic [1:0] {RT_IDLE, RT_MARKED, RT_SETUP} rt_state_e;

  function automatic logic [OFF_W-1:0] default_offset(
    input logic [2:0] sel
  );
    case (sel)
      3'h4: default_offset = DEF_OFF_HLL;
      3'h2: default_offset = DEF_OFF_LHL;
      3'h1: default_offset = DEF_OFF_LLH;
      3'h0: default_offset = DEF_OFF_LLL;
      3'h3: default_offset = DEF_OFF_LHH;
      3'h6: default_offset = DEF_OFF_HHL;
      3'h5: default_offset = DEF_OFF_HLH;
      default: default_offset = DEF_OFF_HHH;
    endcase
  endfunction

endpackage

// File: offset_store.sv
`timescale 1ns/1ns
module offset_store
  import fifo_flag_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF
) (
  input wire logic i_clk, // System clock
  input wire logic i_arst_n, // Async reset
  input wire logic i_load_default, // Load default value
  input wire logic [OFF_W-1:0] i_default, // Default value
  input wire logic i_par_lo, // Parallel low part strobe
  input wire logic i_par_hi, // Parallel high part strobe
  input wire logic [DATA_W-1:0] i_par_data, // Parallel word
  input wire logic i_ser_en, // Serial bit strobe
  input wire logic [4:0] i_ser_idx, // Bit position
  input wire logic i_ser_bit, // Serial bit
  output logic [OFF_W-1:0] o_value // Stored offset
);

  logic [OFF_W-1:0] next_value;

  always_comb begin
    next_value = o_value;
    if (i_load_default) begin
      next_value = i_default;
    end else if (i_par_lo) begin
      next_value[PART_LO_W-1:0] = i_par_data[PART_LO_W-1:0];
    end else if (i_par_hi) begin
      next_value[OFF_W-1:PART_LO_W] =
        i_par_data[OFF_W-PART_LO_W-1:0];
    end else if (i_ser_en) begin
      next_value[i_ser_idx] = i_ser_bit;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_value <= '0;
    end else begin
      o_value <= next_value;
    end
  end

endmodule // offset_store

// File: serial_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Host side serial offset shifter, one bit every other cycle
module serial_host_model (
  input wire logic i_clk, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic i_go, // Start a run
  input wire logic [37:0] i_bits, // Offset bit set
  input wire logic [5:0] i_first, // First bit index
  input wire logic [5:0] i_last, // Last bit index
  output logic o_sclk_en, // Serial clock edge
  output logic o_serial_in, // Serial bit
  output logic o_shift_n, // Shift enable
  output logic o_busy // Run in progress
);
  logic [5:0] idx;
  logic ph;
  logic done;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx <= 6'h00;
      ph <= 1'b0;
      done <= 1'b0;
      o_busy <= 1'b0;
      o_sclk_en <= 1'b0;
      o_serial_in <= 1'b0;
      o_shift_n <= 1'b1;
    end else if (!o_busy) begin
      // Released line toggles so a stale bit is never read
      o_serial_in <= ~o_serial_in;
      if (i_go) begin
        o_busy <= 1'b1;
        o_shift_n <= 1'b0;
        idx <= i_first;
        ph <= 1'b0;
      end
    end else if (!ph) begin
      ph <= 1'b1;
      o_sclk_en <= 1'b0;
      if (done) begin
        o_busy <= 1'b0;
        o_shift_n <= 1'b1;
        done <= 1'b0;
      end else begin
        o_serial_in <= i_bits[idx];
      end
    end else begin
      ph <= 1'b0;
      o_sclk_en <= !done;
      if (idx == i_last) begin
        done <= 1'b1;
      end else begin
        idx <= idx + 6'h01;
      end
    end
  end
endmodule // serial_host_model

// File: test_fifo_flag_offset_retransmit.sv
`timescale 1ns/1ns
module test_fifo_flag_offset_retransmit;
  import fifo_flag_pkg::*;
  logic clk, arst_n, prs_n, wclk, rclk, sclk, we_n, re_n, lsel_n;
  logic shift_n, si, pa, pb, fts, mark, rexmit_n, go;
  logic [35:0] din;
  logic [37:0] bits;
  logic [5:0] first, last;
  logic [35:0] q;
  logic ef_n, ff_n, ae_n, af_n, ft;
  wire logic p_sclk, p_si, p_shift_n, busy;
  int n_mismatch = 0;
  int n_tests = 0;
  // Rows: {select, pick b, pick a, mode strap}, expected default
  logic [22:0] rows [8] = '{{4'h8, 19'h003ff}, {4'h5, 19'h001ff},
    {4'h2, 19'h000ff}, {4'h1, 19'h0007f}, {4'h6, 19'h0003f},
    {4'hd, 19'h0001f}, {4'ha, 19'h0000f}, {4'hf, 19'h00007}};

  fifo_flag_offset_retransmit #(.DATA_W(36), .DEPTH(1024)) dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_partial_reset_n(prs_n),
    .i_wclk_en(wclk), .i_rclk_en(rclk), .i_sclk_en(p_sclk | sclk),
    .i_write_en_n(we_n), .i_read_en_n(re_n), .i_load_select_n(lsel_n),
    .i_serial_enable_n(busy ? p_shift_n : shift_n),
    .i_serial_in(busy ? p_si : si), .i_default_offset_pick_a(pa),
    .i_default_offset_pick_b(pb), .i_flag_timing_select(fts),
    .i_mark(mark), .i_retransmit_n(rexmit_n), .i_write_data_in(din),
    .o_read_data_out(q), .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
    .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n),
    .o_fall_through_mode(ft));

  serial_host_model host (.i_clk(clk), .i_arst_n(arst_n), .i_go(go),
    .i_bits(bits), .i_first(first), .i_last(last), .o_sclk_en(p_sclk),
    .o_serial_in(p_si), .o_shift_n(p_shift_n), .o_busy(busy));

  // ==========================================================
  // Helpers
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [37:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic op(input logic w, r, s, input logic [35:0] d);
    @(posedge clk);
    wclk <= w; rclk <= r; sclk <= s; din <= d;
    @(posedge clk);
    wclk <= 1'b0; rclk <= 1'b0; sclk <= 1'b0;
  endtask
  task automatic rd(input logic [37:0] e);
    @(posedge clk) re_n <= 1'b0;
    op(0, 1, 0, din);
    re_n <= 1'b1;
    settle();
    chk(q, e, "read word");
  endtask
  task automatic full_rst(input logic [3:0] s, input logic f);
    @(posedge clk);
    arst_n <= 0; lsel_n <= s[3]; pb <= s[2]; pa <= s[1]; si <= s[0];
    fts <= f;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    si <= 1'b0;
    #1;
  endtask
  // Idle read edge after each access keeps readbacks apart
  task automatic rb4(input logic [18:0] n, m);
    logic [18:0] v;
    for (int k = 0; k < 4; k++) begin
      v = (k < 2) ? n : m;
      @(posedge clk);
      lsel_n <= 1'b0; we_n <= 1'b1; shift_n <= 1'b1; re_n <= 1'b0;
      op(0, 1, 0, din);
      re_n <= 1'b1;
      settle();
      chk(q, k[0] ? 38'(v[18:10]) : 38'(v[9:0]), "offset readback");
      op(0, 1, 0, din);
    end
  endtask
  task automatic ser(input logic [5:0] f, l);
    @(posedge clk);
    first <= f; last <= l; go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    #1;
    for (int k = 0; k < 200 && busy; k++) @(posedge clk);
    chk(busy, 0, "serial run ends");
  endtask

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 0; prs_n = 1; wclk = 0; rclk = 0; sclk = 0; we_n = 1;
    re_n = 1; lsel_n = 1; shift_n = 1; si = 0; pa = 0; pb = 0; fts = 1;
    mark = 0; rexmit_n = 1; go = 0; din = '0; bits = '0;
    first = '0; last = '0;
    for (int i = 0; i < 8; i++) begin
      full_rst(rows[i][22:19], 1'b1);
      chk(ft, rows[i][19], "timing mode");
      chk({ef_n, ff_n}, rows[i][19] ? 2'h2 : 2'h1, "reset flags");
      chk({ae_n, af_n, q}, {2'h1, 36'h0}, "reset state");
      rb4(rows[i][18:0], rows[i][18:0]);
    end
    $display("test defaults done");
    full_rst(4'h0, 1'b1);
    @(posedge clk) lsel_n <= 1'b0; we_n <= 1'b0;
    op(1, 0, 0, 36'h3);
    op(1, 0, 0, 36'h0);
    op(1, 0, 0, 36'h5);
    op(1, 0, 0, 36'h0);
    rb4(19'h3, 19'h5);
    @(posedge clk) lsel_n <= 1'b1; we_n <= 1'b0;
    for (int i = 0; i < 3; i++) op(1, 0, 0, 36'(i));
    op(0, 1, 0, din);
    settle();
    chk(ae_n, 0, "almost empty at n");
    op(1, 0, 0, 36'h3);
    settle();
    chk(ae_n, 0, "almost empty waits read edge");
    op(0, 1, 0, din);
    settle();
    chk(ae_n, 1, "almost empty at n+1");
    for (int i = 4; i < 1018; i++) op(1, 0, 0, 36'(i));
    settle();
    chk({af_n, ff_n}, 2'h3, "below almost full");
    op(1, 0, 0, 36'h3fa);
    settle();
    chk({af_n, ff_n}, 2'h1, "almost full at depth-m");
    for (int i = 1019; i < 1025; i++) op(1, 0, 0, 36'(i));
    settle();
    chk(ff_n, 0, "full at depth");
    @(posedge clk) we_n <= 1'b1;
    rd(38'h0);
    chk(ff_n, 1, "full released by read");
    $display("test parallel done");
    full_rst(4'h8, 1'b1);
    bits = {19'h000aa, 19'h00155};
    @(posedge clk) lsel_n <= 1'b0;
    ser(6'h00, 6'h13);
    repeat (3) op(0, 0, 1, din);
    @(posedge clk) lsel_n <= 1'b1; we_n <= 1'b0;
    op(1, 0, 0, 36'h9);
    @(posedge clk) lsel_n <= 1'b0; we_n <= 1'b1;
    ser(6'h14, 6'h25);
    rb4(19'h155, 19'h0aa);
    @(posedge clk) prs_n <= 1'b0;
    repeat (3) @(posedge clk);
    prs_n <= 1'b1;
    settle();
    chk(ef_n, 0, "partial reset empties");
    rb4(19'h155, 19'h0aa);
    $display("test serial done");
    full_rst(4'he, 1'b0);
    @(posedge clk) lsel_n <= 1'b1; we_n <= 1'b0;
    for (int i = 0; i < 7; i++) op(1, 0, 0, 36'(i));
    settle();
    chk(ae_n, 0, "almost empty at n");
    op(1, 0, 0, 36'h7);
    settle();
    chk(ae_n, 1, "released on write edge");
    @(posedge clk) we_n <= 1'b1;
    rd(38'h0);
    @(posedge clk) mark <= 1'b1;
    op(0, 1, 0, din);
    rd(38'h1);
    rd(38'h2);
    @(posedge clk) rexmit_n <= 1'b0;
    op(0, 1, 0, din);
    settle();
    chk(ef_n, 0, "retransmit setup");
    @(posedge clk) rexmit_n <= 1'b1;
    op(0, 1, 0, din);
    settle();
    chk(ef_n, 1, "setup ended");
    rd(38'h0);
    rd(38'h1);
    // Last two writes would land on the marked slot
    @(posedge clk) we_n <= 1'b0;
    for (int i = 0; i < 1018; i++) op(1, 0, 0, 36'h5a5);
    @(posedge clk) we_n <= 1'b1;
    rexmit_n <= 1'b0;
    op(0, 1, 0, din);
    @(posedge clk) rexmit_n <= 1'b1;
    op(0, 1, 0, din);
    rd(38'h0);
    $display("test retransmit done");
    full_rst(4'hf, 1'b1);
    @(posedge clk) we_n <= 1'b0;
    for (int i = 0; i < 8; i++) op(1, 0, 0, 36'(i + 16));
    op(0, 1, 0, din);
    settle();
    chk({ef_n, ae_n, q}, {2'h0, 36'h10}, "first word falls through");
    op(1, 0, 0, 36'h0);
    op(0, 1, 0, din);
    settle();
    chk(ae_n, 1, "almost empty at n+2");
    $display("test fall through done");
    print_verdict();
  end
endmodule // test_fifo_flag_offset_retransmit
